//--- rtl/pix_in_cfg.svh
// Constants for the pixel input capture block: widths, field positions, reset values.
// Assumes inclusion by bare name from any design file; definitions only.
`ifndef PIX_IN_CFG_SVH
`define PIX_IN_CFG_SVH
`define PIX_W          24
`define HALF_W         12
`define UPPER_LSB      12
`define SNAP_MSB       23
`define SNAP_LSB       16
`define SNAP_W         8
`define SNAP_RESET     8'h00
`define AUX_W          3
`define DESKEW_W       3
`define FIFO_DEPTH     16
// Word in the FIFO: flag, frame sync, line sync, aux bits, pixel
`define WORD_W         30
`endif

//--- rtl/pix_in_pkg.sv
// Types shared by the pixel input capture block.
// Assumes pix_in_cfg.svh is on the include path.
`include "pix_in_cfg.svh"
package pix_in_pkg;
   // Capture phase within one link clock period
   typedef enum logic [1:0] {
      ph_idle  = 2'b00,
      ph_first = 2'b01,
      ph_second = 2'b11
   } phase_e;

   // One encoder word: pixel or control, per the flag
   typedef struct packed {
      logic                   video;   // Pixel cycle when high
      logic                   fsync;   // Frame sync
      logic                   lsync;   // Line sync
      logic [`AUX_W-1:0]      aux;     // Aux control bits
      logic [`PIX_W-1:0]      pixel;   // Assembled pixel
   } enc_word_s;
endpackage : pix_in_pkg

//--- rtl/pix_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and asynchronous active-high reset; read data registered.
`timescale 1ns/1ps
module pix_fifo #(
   parameter int WIDTH = 30,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input  wire logic             mclk,
   input  wire logic             reset,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW-1:0] wr;      // Write pointer
      logic [AW-1:0] rd;      // Read pointer
      logic [AW:0]   cnt;     // Stored words
      logic          ov;      // Output register holds a word
      logic [WIDTH-1:0] od;   // Output register
   } st_s;

   st_s              st_q, st_d;        // State
   logic [WIDTH-1:0] mem [DEPTH];       // Storage, no reset needed
   logic             push, pop, load;   // Handshake terms

   // Handshakes: output register refills when empty or being taken
   assign in_ready  = (st_q.cnt != (AW+1)'(DEPTH));
   assign push      = in_valid & in_ready;
   assign load      = (st_q.cnt != '0) & (~st_q.ov | out_ready);
   assign pop       = load;
   assign out_valid = st_q.ov;
   assign out_data  = st_q.od;

   // Next state
   always_comb begin
      st_d = st_q;
      if (push) begin
         st_d.wr = st_q.wr + AW'(1);
      end
      if (pop) begin
         st_d.rd = st_q.rd + AW'(1);
         st_d.od = mem[st_q.rd];
         st_d.ov = 1'b1;
      end else if (out_ready) begin
         // Taken with nothing behind it
         st_d.ov = 1'b0;
      end
      st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   // Storage write, kept out of the reset struct
   always_ff @(posedge mclk) begin
      if (push) begin
         mem[st_q.wr] <= in_data;
      end
   end

   // State register
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
endmodule : pix_fifo

//--- rtl/pix_sync.sv
// Two-flop synchroniser for a bundle of pin levels.
// Assumes the inputs are asynchronous to mclk; only the second stage reads the first stage.
`timescale 1ns/1ps
module pix_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             mclk,
   input  wire logic             reset,
   // Levels
   input  wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0]      sync_out
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;   // First stage, read only by s2
      logic [WIDTH-1:0] s2;   // Second stage
   } st_s;

   st_s st_q, st_d;

   // Shift the chain
   always_comb begin
      st_d    = st_q;
      st_d.s1 = async_in;
      st_d.s2 = st_q.s1;
   end

   // Registers
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign sync_out = st_q.s2;
endmodule : pix_sync

//--- rtl/pix_capture.sv
// Pixel input front end: samples the pixel bus on link clock edges, builds
// encoder words, buffers them in a FIFO. Assumes link pins are asynchronous
// to mclk, which runs well above twice the link clock rate.
//
// What this block does
// - Width select high: upper lines are pixel top
// - Same mode: lower lines are bottom, one edge
// - Width select low: half pixel each edge
// - Narrow mode ignores upper lines for pixels
// - Narrow mode copies lines 23:16 to snapshot
// - Flag picks pixel or control every cycle
// - Flag high: pass 24-bit pixel on
// - Flag low: send syncs and aux bits
// - Differential mode latches at clock crossover
// - Host port low: pins become deskew inputs
`timescale 1ns/1ps
`include "pix_in_cfg.svh"
module pix_capture #(
   parameter int DEPTH = `FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic                   mclk,
   input  wire logic                   reset,
   // Link clock pins
   input  wire logic                   pixel_clock_in_p,
   input  wire logic                   pixel_clock_in_n,
   input  wire logic                   diff_clock_mode,
   // Pixel bus pins
   input  wire logic [`PIX_W-1:0]      pixel_data,
   input  wire logic                   active_video_flag,
   input  wire logic                   line_sync,
   input  wire logic                   frame_sync,
   input  wire logic [`AUX_W-1:0]      aux_control_bits,
   // Configuration pins
   input  wire logic                   bus_width_select,
   input  wire logic                   host_port_select,
   input  wire logic [`DESKEW_W-1:0]   deskew_pins,
   // Encoder side
   output logic                        enc_valid,
   input  wire logic                   enc_ready,
   output logic                        enc_video,
   output logic [`PIX_W-1:0]           enc_pixel,
   output logic                        enc_line_sync,
   output logic                        enc_frame_sync,
   output logic [`AUX_W-1:0]           enc_aux,
   // Status
   output logic [`SNAP_W-1:0]          user_config_snapshot,
   output logic [`DESKEW_W-1:0]        deskew_setting,
   output logic                        overflow
);
   // Synchronised bundle: data, flag, two syncs, aux, five single pins, deskew
   localparam int SW = `PIX_W + `AUX_W + `DESKEW_W + 8;

   typedef struct packed {
      pix_in_pkg::phase_e        phase;    // Half-pixel progress
      logic                      clk_q;    // Last sampled link clock
      logic [`HALF_W-1:0]        low_half; // First-edge half in narrow mode
      logic [`SNAP_W-1:0]        snap;     // User config snapshot
      logic [`DESKEW_W-1:0]      deskew;   // Deskew setting
      logic                      word_v;   // Word ready for the FIFO
      pix_in_pkg::enc_word_s     word;     // Pending encoder word
      logic                      ovf;      // Sticky FIFO overflow
   } st_s;

   st_s                    st_q, st_d;
   logic [SW-1:0]          sync_bus;        // Synchronised pins
   logic [`PIX_W-1:0]      s_data;
   logic                   s_flag, s_lsync, s_fsync, s_clkp, s_clkn, s_diff;
   logic                   s_wide, s_host;
   logic [`AUX_W-1:0]      s_aux;
   logic [`DESKEW_W-1:0]   s_dk;
   logic                   link_clk;        // Recovered clock level
   logic                   rise, fall;      // Link clock edges
   logic                   fifo_ready;
   pix_in_pkg::enc_word_s  fifo_out;

   // Builds one encoder word; flag chooses pixel or control content
   function automatic pix_in_pkg::enc_word_s make_word(
      input logic              flag,
      input logic [`PIX_W-1:0] pix,
      input logic              ls,
      input logic              fs,
      input logic [`AUX_W-1:0] aux
   );
      pix_in_pkg::enc_word_s w;
      w       = '0;
      w.video = flag;
      if (flag) begin
         w.pixel = pix;
      end else begin
         w.lsync = ls;
         w.fsync = fs;
         w.aux   = aux;
      end
      return w;
   endfunction : make_word

   // All link pins pass two flops before any logic
   pix_sync #(
      .WIDTH (SW)
   ) u_sync (
      .mclk     (mclk),
      .reset    (reset),
      .async_in ({pixel_data, active_video_flag, line_sync, frame_sync,
                  aux_control_bits, pixel_clock_in_p, pixel_clock_in_n,
                  diff_clock_mode, bus_width_select, host_port_select,
                  deskew_pins}),
      .sync_out (sync_bus)
   );

   assign {s_data, s_flag, s_lsync, s_fsync, s_aux, s_clkp, s_clkn,
           s_diff, s_wide, s_host, s_dk} = sync_bus;

   // crossover as latch reference
   // In differential mode the clock is high where p is above n; the negative
   // leg is held at ground in single-ended use, so only p matters there.
   // single-ended uses positive leg
   assign link_clk = s_diff ? (s_clkp & ~s_clkn) : s_clkp;
   assign rise     = link_clk & ~st_q.clk_q;
   assign fall     = ~link_clk & st_q.clk_q;

   // Capture and assembly
   always_comb begin
      st_d        = st_q;
      st_d.clk_q  = link_clk;
      // A word not taken this cycle is dropped and flagged, since the pixel
      // bus cannot be stalled; the FIFO absorbs encoder hiccups.
      if (st_q.word_v & fifo_ready) begin
         st_d.word_v = 1'b0;
      end else if (st_q.word_v) begin
         st_d.word_v = 1'b0;
         st_d.ovf    = 1'b1;
      end
      // deskew pins when host port low
      if (!s_host) begin
         st_d.deskew = s_dk;
      end
      if (s_wide) begin
         // Wide mode: whole pixel on the rising edge
         st_d.phase = pix_in_pkg::ph_idle;
         if (rise) begin
            st_d.word   = make_word(s_flag, {s_data[`PIX_W-1:`UPPER_LSB],
                                             s_data[`HALF_W-1:0]},
                                    s_lsync, s_fsync, s_aux);
            st_d.word_v = 1'b1;
         end
      end else begin
         st_d.snap = s_data[`SNAP_MSB:`SNAP_LSB];
         unique case (st_q.phase)
            pix_in_pkg::ph_idle,
            pix_in_pkg::ph_second: begin
               if (rise) begin
                  st_d.low_half = s_data[`HALF_W-1:0];
                  st_d.phase    = pix_in_pkg::ph_first;
               end
            end
            pix_in_pkg::ph_first: begin
               if (fall) begin
                  st_d.word   = make_word(s_flag, {s_data[`HALF_W-1:0],
                                                   st_q.low_half},
                                          s_lsync, s_fsync, s_aux);
                  st_d.word_v = 1'b1;
                  st_d.phase  = pix_in_pkg::ph_second;
               end
            end
            default: begin
               st_d.phase = pix_in_pkg::ph_idle;
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         st_q      <= '0;
         st_q.snap <= `SNAP_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   // Word buffer toward the encoder
   pix_fifo #(
      .WIDTH (`WORD_W),
      .DEPTH (DEPTH)
   ) u_fifo (
      .mclk      (mclk),
      .reset     (reset),
      .in_valid  (st_q.word_v),
      .in_ready  (fifo_ready),
      .in_data   (st_q.word),
      .out_valid (enc_valid),
      .out_ready (enc_ready),
      .out_data  (fifo_out)
   );

   // Outputs
   assign enc_video            = fifo_out.video;
   assign enc_pixel            = fifo_out.pixel;
   assign enc_line_sync        = fifo_out.lsync;
   assign enc_frame_sync       = fifo_out.fsync;
   assign enc_aux              = fifo_out.aux;
   assign user_config_snapshot = st_q.snap;
   assign deskew_setting       = st_q.deskew;
   assign overflow             = st_q.ovf;
endmodule : pix_capture

//--- testbench/pix_capture_sva.sv
// Checker for the pixel capture block, watching its ports only.
// Assumes one mclk domain with an asynchronous active-high reset.
`timescale 1ns/1ps
`include "pix_in_cfg.svh"
module pix_capture_chk (
   // Clock and reset
   input wire logic                 mclk,
   input wire logic                 reset,
   // Link and configuration pins
   input wire logic                 pixel_clock_in_p,
   input wire logic [`PIX_W-1:0]    pixel_data,
   input wire logic                 bus_width_select,
   input wire logic                 host_port_select,
   input wire logic [`DESKEW_W-1:0] deskew_pins,
   // Encoder side and status
   input wire logic                 enc_valid,
   input wire logic                 enc_ready,
   input wire logic                 enc_video,
   input wire logic [`PIX_W-1:0]    enc_pixel,
   input wire logic                 enc_line_sync,
   input wire logic                 enc_frame_sync,
   input wire logic [`AUX_W-1:0]    enc_aux,
   input wire logic [`SNAP_W-1:0]   user_config_snapshot,
   input wire logic [`DESKEW_W-1:0] deskew_setting,
   input wire logic                 overflow
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   // Settle spans cover the pin synchroniser lag with margin
   sequence snap_settle;
      (!bus_width_select && $stable(pixel_data[`SNAP_MSB:`SNAP_LSB]))[*8];
   endsequence
   sequence skew_settle;
      (!host_port_select && $stable(deskew_pins))[*8];
   endsequence
   // A link edge that should yield a word while the output is empty
   sequence wide_edge;
      $rose(pixel_clock_in_p) && bus_width_select && !enc_valid;
   endsequence
   sequence half_edge;
      $fell(pixel_clock_in_p) && !bus_width_select && !enc_valid;
   endsequence
   ctl_clear_a:
   assert property (enc_valid && enc_video |-> !enc_line_sync && !enc_frame_sync && !enc_aux)
      else $error("control bits set on a pixel word");
   pix_clear_a:
   assert property (enc_valid && !enc_video |-> enc_pixel == '0)
      else $error("pixel bits set on a control word");
   word_hold_a:
   assert property (enc_valid && !enc_ready |=> enc_valid
      && $stable({enc_video, enc_pixel, enc_aux, enc_line_sync, enc_frame_sync}))
      else $error("stalled word changed");
   snap_track_a:
   assert property (snap_settle |-> user_config_snapshot == pixel_data[`SNAP_MSB:`SNAP_LSB])
      else $error("snapshot does not follow upper lines");
   skew_track_a:
   assert property (skew_settle |-> deskew_setting == deskew_pins)
      else $error("deskew setting does not follow pins");
   wide_take_a:
   assert property (wide_edge |-> ##[2:8] enc_valid)
      else $error("wide edge gave no word");
   half_take_a:
   assert property (half_edge |-> ##[2:8] enc_valid)
      else $error("narrow pair gave no word");
   ovf_stick_a:
   assert property (overflow |=> overflow)
      else $error("overflow flag cleared");
   reset_clear_a:
   assert property ($fell(reset) |-> !enc_valid && !overflow)
      else $error("outputs not clear after reset");
endmodule : pix_capture_chk
bind pix_capture pix_capture_chk chk_u (.mclk(mclk), .reset(reset),
   .pixel_clock_in_p(pixel_clock_in_p), .pixel_data(pixel_data),
   .bus_width_select(bus_width_select), .host_port_select(host_port_select),
   .deskew_pins(deskew_pins), .enc_valid(enc_valid), .enc_ready(enc_ready),
   .enc_video(enc_video), .enc_pixel(enc_pixel), .enc_line_sync(enc_line_sync),
   .enc_frame_sync(enc_frame_sync), .enc_aux(enc_aux), .overflow(overflow),
   .user_config_snapshot(user_config_snapshot), .deskew_setting(deskew_setting));

//--- testbench/gfx_ctl_model.sv
// Graphics controller model driving the pixel bus and the link clock legs.
// Assumes callers run one transfer at a time; the clock stands still between.
`timescale 1ns/1ps
`include "pix_in_cfg.svh"
module gfx_ctl_model (
   // Clocking style
   input wire logic          diff,
   // Link clock legs
   output logic              clk_p,
   output logic              clk_n,
   // Pixel bus
   output logic [`PIX_W-1:0] data,
   output logic              flag,
   output logic              ls,
   output logic              fs,
   output logic [`AUX_W-1:0] aux
);
   initial {clk_p, clk_n, data, flag, fs, ls, aux} = '0;
   // One pixel period of 64 ns; data leads each edge by 16 ns
   task automatic send(input logic wide, input pix_in_pkg::enc_word_s w,
                       input logic [11:0] up);
      {flag, fs, ls, aux} <= w[29:24];
      // low half first, negative leg high in diff mode, grounded otherwise
      data <= wide ? w.pixel : {up, w.pixel[11:0]};
      clk_n <= diff;
      // in diff mode the legs cross over at each edge
      #16 clk_p <= 1'b1;
      clk_n <= 1'b0;
      #16 if (!wide) data[11:0] <= w.pixel[23:12];
      #16 clk_p <= 1'b0;
      clk_n <= diff;
      #16;
   endtask : send
   // Released bus shows the inverse of its last value
   task automatic release_bus();
      data <= ~data;
   endtask : release_bus
endmodule : gfx_ctl_model

//--- testbench/pix_capture_test.sv
// Self-checking bench: controller model in front, queue model behind.
// Assumes the design's pins pass a short synchroniser before capture.
`timescale 1ns/1ps
`include "pix_in_cfg.svh"
module pix_capture_test;
   logic mclk = 0, reset = 1, enc_ready = 0, bws = 1, hps = 1, dcm = 0;
   logic [`DESKEW_W-1:0]  skew = '0, dset;
   logic [1:0]            rdy_mode = 0;   // 0 stall, 1 ready, 2 random
   logic                  cp, cn, flg, ls, fs, ev, evid, els, efs, ovf;
   logic [`PIX_W-1:0]     dat, epix;
   logic [`AUX_W-1:0]     aux, eaux;
   logic [`SNAP_W-1:0]    snap;
   pix_in_pkg::enc_word_s exp_q[$], got_w;
   int                    seed = 38290, failures = 0, total_checks = 0, m, i;
   initial forever #2.5 mclk = ~mclk;
   gfx_ctl_model ctl_u (.diff(dcm), .clk_p(cp), .clk_n(cn), .data(dat), .flag(flg),
      .ls(ls), .fs(fs), .aux(aux));
   pix_capture #(.DEPTH(`FIFO_DEPTH)) dut_u (.mclk(mclk), .reset(reset),
      .pixel_clock_in_p(cp), .pixel_clock_in_n(cn), .diff_clock_mode(dcm),
      .pixel_data(dat), .active_video_flag(flg), .line_sync(ls), .frame_sync(fs),
      .aux_control_bits(aux), .bus_width_select(bws), .host_port_select(hps),
      .deskew_pins(skew), .enc_valid(ev), .enc_ready(enc_ready), .enc_video(evid),
      .enc_pixel(epix), .enc_line_sync(els), .enc_frame_sync(efs), .enc_aux(eaux),
      .user_config_snapshot(snap), .deskew_setting(dset), .overflow(ovf));
   task automatic check(input logic [29:0] got, input logic [29:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic end_of_test();
      $display("checks=%0d mismatches=%0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : end_of_test
   // Encoder ready follows rdy_mode; in mode 2 it stalls at random to keep words standing
   always @(posedge mclk) enc_ready <= (rdy_mode == 2) ? 1'($random(seed)) : rdy_mode[0];
   // Every accepted word against the queue model; empty queue never matches
   always @(posedge mclk) if (ev === 1'b1 && enc_ready === 1'b1) begin
      got_w = exp_q.size() ? exp_q.pop_front() : '1;
      check({evid, efs, els, eaux, epix}, got_w);
   end
   // Random word on the pins; expectation masks what the flag discards
   task automatic push_one(input logic wide, input logic keep);
      pix_in_pkg::enc_word_s v, e;
      v = 30'($random(seed));
      e = v;
      if (e.video) e[29:24] = 6'h20;
      else e.pixel = '0;
      if (keep) exp_q.push_back(e);
      ctl_u.send(wide, v, 12'($random(seed)));
   endtask : push_one
   // Bounded wait for the queue model to empty
   task automatic drain();
      for (i = 0; i < 400 && exp_q.size() != 0; i++) @(posedge mclk);
      check(30'(exp_q.size()), 30'h0);
   endtask : drain
   initial #60000 begin
      failures++;
      end_of_test();
   end
   initial begin
      repeat (4) @(posedge mclk);
      reset <= 1'b0;
      repeat (6) @(posedge mclk);
      check({29'h0, ovf}, 30'h0);
      // Both widths, each with single-ended and crossover clocking
      for (m = 0; m < 4; m++) begin
         @(posedge mclk);
         bws <= m[0];
         dcm <= m[1];
         hps <= m[1];
         skew <= 3'($random(seed));
         rdy_mode <= 2;
         repeat (8) @(posedge mclk);
         for (int k = 0; k < 8; k++) push_one(m[0], 1'b1);
         ctl_u.release_bus();
         repeat (10) @(posedge mclk);
         if (!m[0]) check(30'(snap), 30'(dat[`SNAP_MSB:`SNAP_LSB]));
         if (!m[1]) check(30'(dset), 30'(skew));
         drain();
         $display("mode %0d done", m);
      end
      // Fill past depth plus the output register with the encoder stalled;
      // the last word is refused
      rdy_mode <= 0;
      for (int k = 0; k < 18; k++) push_one(1'b1, k < `FIFO_DEPTH + 1);
      repeat (8) @(posedge mclk);
      check({29'h0, ovf}, 30'h1);
      rdy_mode <= 2;
      drain();
      check({29'h0, ovf}, 30'h1);
      $display("overflow test done");
      end_of_test();
   end
endmodule : pix_capture_test
